// ==== tpg_timer.sv ====
// One 16-bit timer channel: pulse generation and edge capture
//
// Notes on behaviour
// - Compare values set period and duty of the square wave on the counter.
// - Initial output flip-flop state chooses active-low or active-high pulse.
// - Timer waveform drives its output pin, shared with a port bit.
// - Output flip-flop toggles on match with either compare register.
// - Double-buffered low compare reloads from its buffer on period match.
// - Trigger A rising edge latches counter into first capture register in modes 01 and 10.
// - Trigger A rising edge raises its interrupt except in pulse-width mode.
// - Both match-toggle enables set makes both matches toggle the output.
// - First capture load may toggle the output flip-flop when selected.
// - Trigger A may serve as counter clock, one count per rising edge.
// - Mode 11 captures on gate flip-flop rising and falling edges.
// - Pulse-width mode captures trigger A rising then falling edge.
// - Only mode 10 raises trigger A interrupt on falling edge.
// - Time-difference mode: trigger B rise captures second and interrupts.
// - Counter clears on period match unless clearing is disabled.
// - Clear enable off lets the counter run free for capture work.
// - Unbuffered writes load compare and buffer; buffered writes buffer only.
// - Capture mode 00, the reset state, disables all capture.
`timescale 1ns/1ps
`include "tpg_defines.svh"
module tpg_timer
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [`TPG_ADDR_W-1:0] reg_addr,
    input wire logic [`TPG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`TPG_DATA_W-1:0] reg_rdata,
    input wire logic trigger_in_a,
    input wire logic trigger_in_b,
    input wire logic gate_flipflop,
    output logic pulse_out_pin_a,
    output logic ext_irq_a,
    output logic ext_irq_b,
    output logic low_match_irq,
    output logic period_match_irq
);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [2:0] run_q;
    logic [3:0] mode_q;
    logic [2:0] tog_en_q;
    logic db_en_q;
    tpg_cap_mode_t cap_mode;
    logic run_en;
    logic ext_clk_sel;
    logic clear_en;

    logic wr_run;
    logic wr_mode;
    logic wr_tog;
    logic wr_low;
    logic wr_per;

    assign wr_run = reg_wr && (reg_addr == `TPG_OFS_RUN);
    assign wr_mode = reg_wr && (reg_addr == `TPG_OFS_MODE);
    assign wr_tog = reg_wr && (reg_addr == `TPG_OFS_TOGCTL);
    assign wr_low = reg_wr && (reg_addr == `TPG_OFS_CMPLOW);
    assign wr_per = reg_wr && (reg_addr == `TPG_OFS_CMPPER);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run_q <= `TPG_RUN_RST;
        end else if (wr_run) begin
            run_q <= reg_wdata[`TPG_RUN_PORTDAT:`TPG_RUN_EN];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mode_q <= `TPG_MODE_RST;
        end else if (wr_mode) begin
            mode_q <= reg_wdata[`TPG_MODE_EXTCLK:`TPG_MODE_CLE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tog_en_q <= `TPG_TOG_RST;
            db_en_q <= 1'b0;
        end else if (wr_tog) begin
            tog_en_q <= reg_wdata[`TPG_TOG_CAPEN:`TPG_TOG_LOWEN];
            db_en_q <= reg_wdata[`TPG_TOG_DBEN];
        end
    end

    assign run_en = run_q[`TPG_RUN_EN];
    assign ext_clk_sel = mode_q[`TPG_MODE_EXTCLK];
    assign clear_en = mode_q[`TPG_MODE_CLE];
    assign cap_mode = tpg_cap_mode_t'(mode_q[`TPG_MODE_CAP_HI:`TPG_MODE_CAP_LO]);

    // ------------------------------------------------------------
    // Input edges
    // ------------------------------------------------------------
    tpg_edge_t edge_a;
    tpg_edge_t edge_b;
    tpg_edge_t edge_gate;
    logic gate_last_q;

    tpg_sync_edge u_sync_a (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin(trigger_in_a),
        .edge_o(edge_a)
    );

    tpg_sync_edge u_sync_b (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin(trigger_in_b),
        .edge_o(edge_b)
    );

    // Gate flip-flop comes from same-clock logic, so no synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gate_last_q <= 1'b0;
        end else begin
            gate_last_q <= gate_flipflop;
        end
    end

    assign edge_gate.rise = gate_flipflop & ~gate_last_q;
    assign edge_gate.fall = ~gate_flipflop & gate_last_q;

    // ------------------------------------------------------------
    // Up-counter and compares
    // ------------------------------------------------------------
    logic [`TPG_DATA_W-1:0] up_counter_q;
    logic [`TPG_DATA_W-1:0] compare_low;
    logic [`TPG_DATA_W-1:0] compare_period;
    logic count_tick;
    logic low_match;
    logic per_match;

    // external rising edges as count clock
    assign count_tick = run_en && (ext_clk_sel ? edge_a.rise : 1'b1);

    // Matches are taken as the counter leaves the matching value
    assign low_match = count_tick && (up_counter_q == compare_low);
    assign per_match = count_tick && (up_counter_q == compare_period);

    // clear enable off gives free-running count
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            up_counter_q <= `TPG_ZERO;
        end else if (per_match && clear_en) begin
            up_counter_q <= `TPG_ZERO;
        end else if (count_tick) begin
            up_counter_q <= up_counter_q + `TPG_ONE;
        end
    end

    tpg_cmp_buf u_cmp_low (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr(wr_low),
        .wdata(reg_wdata),
        .db_en(db_en_q),
        .xfer(per_match),
        .value(compare_low)
    );

    // Period compare has no buffer
    tpg_cmp_buf u_cmp_per (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr(wr_per),
        .wdata(reg_wdata),
        .db_en(1'b0),
        .xfer(1'b0),
        .value(compare_period)
    );

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    logic [`TPG_DATA_W-1:0] capture_first_q;
    logic [`TPG_DATA_W-1:0] capture_second_q;
    logic capture_first_load;
    logic capture_second_load;

    always_comb begin
        capture_first_load = 1'b0;
        capture_second_load = 1'b0;
        unique case (cap_mode)
            TPG_CAP_OFF: begin
                capture_first_load = 1'b0;
                capture_second_load = 1'b0;
            end
            TPG_CAP_DIFF: begin
                capture_first_load = edge_a.rise;
                capture_second_load = edge_b.rise;
            end
            TPG_CAP_WIDTH: begin
                capture_first_load = edge_a.rise;
                capture_second_load = edge_a.fall;
            end
            TPG_CAP_GATE: begin
                capture_first_load = edge_gate.rise;
                capture_second_load = edge_gate.fall;
            end
        endcase
    end

    // Second capture is overwritten on every load; software must save it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            capture_first_q <= `TPG_ZERO;
        end else if (capture_first_load) begin
            capture_first_q <= up_counter_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            capture_second_q <= `TPG_ZERO;
        end else if (capture_second_load) begin
            capture_second_q <= up_counter_q;
        end
    end

    // ------------------------------------------------------------
    // Output toggle flip-flop
    // ------------------------------------------------------------
    logic output_toggle_ff_q;
    logic [1:0] ff_cmd;
    logic toggle;

    assign ff_cmd = reg_wdata[`TPG_TOG_CMD_HI:`TPG_TOG_CMD_LO];

    // first capture load toggles
    // Simultaneous triggers cancel pairwise, as each is an inversion
    assign toggle = (low_match & tog_en_q[`TPG_TOG_LOWEN])
                  ^ (per_match & tog_en_q[`TPG_TOG_PEREN])
                  ^ (capture_first_load & tog_en_q[`TPG_TOG_CAPEN]);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            output_toggle_ff_q <= 1'b0;
        end else if (wr_tog && ff_cmd == `TPG_FF_CLR) begin
            output_toggle_ff_q <= 1'b0;
        end else if (wr_tog && ff_cmd == `TPG_FF_SET) begin
            output_toggle_ff_q <= 1'b1;
        end else if (wr_tog && ff_cmd == `TPG_FF_INV) begin
            output_toggle_ff_q <= ~output_toggle_ff_q ^ toggle;
        end else begin
            output_toggle_ff_q <= output_toggle_ff_q ^ toggle;
        end
    end

    // pin shows timer or port bit
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pulse_out_pin_a <= 1'b0;
        end else if (run_q[`TPG_RUN_PINSEL]) begin
            pulse_out_pin_a <= output_toggle_ff_q;
        end else begin
            pulse_out_pin_a <= run_q[`TPG_RUN_PORTDAT];
        end
    end

    // ------------------------------------------------------------
    // Interrupt request lines
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ext_irq_a <= 1'b0;
            ext_irq_b <= 1'b0;
            low_match_irq <= 1'b0;
            period_match_irq <= 1'b0;
        end else begin
            ext_irq_a <= (cap_mode == TPG_CAP_WIDTH) ? edge_a.fall
                                                     : edge_a.rise;
            ext_irq_b <= edge_b.rise;
            low_match_irq <= low_match;
            period_match_irq <= per_match;
        end
    end

    // ------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------
    logic [`TPG_DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = `TPG_ZERO;
        unique case (reg_addr)
            `TPG_OFS_RUN: begin
                rd_mux[`TPG_RUN_PORTDAT:`TPG_RUN_EN] = run_q;
            end
            `TPG_OFS_MODE: begin
                rd_mux[`TPG_MODE_EXTCLK:`TPG_MODE_CLE] = mode_q;
            end
            `TPG_OFS_TOGCTL: begin
                rd_mux[`TPG_TOG_CAPEN:`TPG_TOG_LOWEN] = tog_en_q;
                rd_mux[`TPG_TOG_CMD_HI:`TPG_TOG_CMD_LO] = `TPG_FF_KEEP;
                rd_mux[`TPG_TOG_DBEN] = db_en_q;
                rd_mux[`TPG_TOG_FF] = output_toggle_ff_q;
            end
            `TPG_OFS_CMPLOW: begin
                rd_mux = compare_low;
            end
            `TPG_OFS_CMPPER: begin
                rd_mux = compare_period;
            end
            `TPG_OFS_CAPTURE_FIRST: begin
                rd_mux = capture_first_q;
            end
            `TPG_OFS_CAPTURE_SECOND: begin
                rd_mux = capture_second_q;
            end
            `TPG_OFS_COUNT: begin
                rd_mux = up_counter_q;
            end
            default: begin
                rd_mux = `TPG_ZERO;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= `TPG_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= `TPG_ZERO;
        end
    end

endmodule

// ==== tpg_defines.svh ====
// Register map, field positions and reset values of the pulse timer
`ifndef TPG_DEFINES_SVH
`define TPG_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define TPG_ADDR_W 4
`define TPG_DATA_W 16

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TPG_OFS_RUN 4'h0
`define TPG_OFS_MODE 4'h1
`define TPG_OFS_TOGCTL 4'h2
`define TPG_OFS_CMPLOW 4'h3
`define TPG_OFS_CMPPER 4'h4
`define TPG_OFS_CAPTURE_FIRST 4'h5
`define TPG_OFS_CAPTURE_SECOND 4'h6
`define TPG_OFS_COUNT 4'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPG_RUN_EN 0
`define TPG_RUN_PINSEL 1
`define TPG_RUN_PORTDAT 2
`define TPG_MODE_CLE 0
`define TPG_MODE_CAP_LO 1
`define TPG_MODE_CAP_HI 2
`define TPG_MODE_EXTCLK 3
`define TPG_TOG_LOWEN 0
`define TPG_TOG_PEREN 1
`define TPG_TOG_CAPEN 2
`define TPG_TOG_CMD_LO 4
`define TPG_TOG_CMD_HI 5
`define TPG_TOG_DBEN 6
`define TPG_TOG_FF 7

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TPG_ZERO 16'h0000
`define TPG_ONE 16'h0001
`define TPG_RUN_RST 3'h0
`define TPG_MODE_RST 4'h1
`define TPG_TOG_RST 3'h0
`define TPG_FF_INV 2'h0
`define TPG_FF_CLR 2'h1
`define TPG_FF_SET 2'h2
`define TPG_FF_KEEP 2'h3

`endif

// ==== tpg_pkg.sv ====
// Types shared by the pulse timer modules
package tpg_pkg;

    // ------------------------------------------------------------
    // Capture modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TPG_CAP_OFF = 2'b00,
        TPG_CAP_DIFF = 2'b01,
        TPG_CAP_WIDTH = 2'b10,
        TPG_CAP_GATE = 2'b11
    } tpg_cap_mode_t;

    // ------------------------------------------------------------
    // Edge events of one input
    // ------------------------------------------------------------
    typedef struct packed {
        logic rise;
        logic fall;
    } tpg_edge_t;

endpackage

// ==== tpg_sync_edge.sv ====
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
module tpg_sync_edge
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pin,
    output tpg_edge_t edge_o
);

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Only sync_q reads meta_q
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign edge_o.rise = sync_q & ~last_q;
    assign edge_o.fall = ~sync_q & last_q;

endmodule

// ==== tpg_cmp_buf.sv ====
// Compare register with optional double buffer
`timescale 1ns/1ps
`include "tpg_defines.svh"
module tpg_cmp_buf
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr,
    input wire logic [`TPG_DATA_W-1:0] wdata,
    input wire logic db_en,
    input wire logic xfer,
    output logic [`TPG_DATA_W-1:0] value
);

    // ------------------------------------------------------------
    // Buffer and compare value
    // ------------------------------------------------------------
    logic [`TPG_DATA_W-1:0] buf_q;
    logic [`TPG_DATA_W-1:0] cmp_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            buf_q <= `TPG_ZERO;
        end else if (wr) begin
            buf_q <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cmp_q <= `TPG_ZERO;
        end else if (wr && !db_en) begin
            cmp_q <= wdata;
        end else if (xfer && db_en) begin
            cmp_q <= buf_q;
        end
    end

    assign value = cmp_q;

endmodule

// ==== tpg_timer_checker.sv ====
// Port-level assertions for the pulse timer channel
`timescale 1ns/1ps
`include "tpg_defines.svh"
module tpg_timer_checker
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [`TPG_ADDR_W-1:0] reg_addr,
    input wire logic [`TPG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`TPG_DATA_W-1:0] reg_rdata,
    input wire logic trigger_in_a,
    input wire logic trigger_in_b,
    input wire logic gate_flipflop,
    input wire logic pulse_out_pin_a,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic low_match_irq,
    input wire logic period_match_irq
);
    // ------------------------------------------------------------
    // Shadow of the settings written by software
    // ------------------------------------------------------------
    logic [3:0] mode_q;
    logic [2:0] run_q;
    logic [6:0] tog_q;
    logic [15:0] per_q;
    logic pw;
    logic hw_int;
    assign pw = mode_q[2:1] == 2'h2;
    assign hw_int = run_q[0] && !mode_q[3];
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mode_q <= 4'h1;
            run_q <= 3'h0;
            tog_q <= 7'h00;
            per_q <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                `TPG_OFS_RUN: run_q <= reg_wdata[2:0];
                `TPG_OFS_MODE: mode_q <= reg_wdata[3:0];
                `TPG_OFS_TOGCTL: tog_q <= reg_wdata[6:0];
                `TPG_OFS_CMPPER: per_q <= reg_wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b |=> !pulse_out_pin_a && !ext_irq_a && !ext_irq_b)
        else $error("outputs not quiet after reset");
    a_rise_irq: assert property (
        $rose(trigger_in_a) && !pw |-> ##[1:4] ext_irq_a)
        else $error("no irq a after rising edge");
    a_fall_irq: assert property (
        $fell(trigger_in_a) && pw |-> ##[1:4] ext_irq_a)
        else $error("no irq a after falling edge");
    a_fall_quiet: assert property (
        $fell(trigger_in_a) && !pw |-> ##2 !ext_irq_a ##1 !ext_irq_a)
        else $error("irq a on falling edge outside width mode");
    a_b_irq: assert property (
        $rose(trigger_in_b) |-> ##[1:4] ext_irq_b)
        else $error("no irq b after rising edge");
    a_period_len: assert property (
        period_match_irq && hw_int && mode_q[0] && per_q == 16'h0004
        |-> ##5 (period_match_irq || !hw_int))
        else $error("period match spacing wrong");
    a_free_run: assert property (
        period_match_irq && hw_int && !mode_q[0] && !$past(mode_q[0])
        && per_q == 16'h0004 |-> ##5 !period_match_irq)
        else $error("counter cleared with clear disabled");
    a_low_tog: assert property (
        low_match_irq && !period_match_irq && tog_q[0] && !tog_q[2]
        && run_q[1] |=> $changed(pulse_out_pin_a))
        else $error("low match did not toggle output");
    a_per_tog: assert property (
        period_match_irq && !low_match_irq && tog_q[1] && !tog_q[2]
        && run_q[1] |=> $changed(pulse_out_pin_a))
        else $error("period match did not toggle output");
    a_cap_tog: assert property (
        ext_irq_a && mode_q[2:1] == 2'h1 && tog_q[2] && !tog_q[1]
        && run_q[1] |-> ##[1:2] $changed(pulse_out_pin_a))
        else $error("capture load did not toggle output");
    c_irq_b: cover property (ext_irq_b);
    c_low_tog: cover property (low_match_irq && tog_q[0]);
    c_width_fall: cover property ($fell(trigger_in_a) && pw);
endmodule

bind tpg_timer tpg_timer_checker tpg_timer_checker_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_in_a(trigger_in_a),
    .trigger_in_b(trigger_in_b), .gate_flipflop(gate_flipflop),
    .pulse_out_pin_a(pulse_out_pin_a), .ext_irq_a(ext_irq_a),
    .ext_irq_b(ext_irq_b), .low_match_irq(low_match_irq),
    .period_match_irq(period_match_irq)
);

// ==== tpg_pulse_src.sv ====
// External pulse sources on the trigger and gate pins
`timescale 1ns/1ps
module tpg_pulse_src (
    input wire logic sys_clk,
    output logic trig_a,
    output logic trig_b,
    output logic gate
);
    initial begin
        trig_a = 1'b0;
        trig_b = 1'b0;
        gate = 1'b0;
    end
    // High for width clocks, then low for six so the synchroniser keeps up
    task automatic pulse(input int sel, input int width);
        int i;
        @(posedge sys_clk);
        case (sel)
            0: trig_a <= 1'b1;
            1: trig_b <= 1'b1;
            default: gate <= 1'b1;
        endcase
        for (i = 0; i < width; i++) @(posedge sys_clk);
        trig_a <= 1'b0;
        trig_b <= 1'b0;
        gate <= 1'b0;
        for (i = 0; i < 6; i++) @(posedge sys_clk);
    endtask
endmodule

// ==== tpg_timer_tb.sv ====
// Self-checking testbench of the pulse timer channel
`timescale 1ns/1ps
`include "tpg_defines.svh"
module tpg_timer_tb
    import tpg_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic trig_a, trig_b, gate, pin, irq_a, irq_b, low_i, per_i;
    int mismatches = 0;
    int compares = 0;
    always #12.5 sys_clk = ~sys_clk;
    tpg_timer tpg_timer_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_in_a(trig_a),
        .trigger_in_b(trig_b), .gate_flipflop(gate),
        .pulse_out_pin_a(pin), .ext_irq_a(irq_a), .ext_irq_b(irq_b),
        .low_match_irq(low_i), .period_match_irq(per_i));
    tpg_pulse_src tpg_pulse_src_i (.sys_clk(sys_clk), .trig_a(trig_a),
        .trig_b(trig_b), .gate(gate));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_per();
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge sys_clk);
            #1;
            if (per_i === 1'b1) return;
        end
        mismatches++;
        $display("MISMATCH t=%0t period match timeout", $time);
        give_verdict();
    endtask
    task automatic watch(input int n, output int ch, output int hi);
        logic last;
        last = pin;
        ch = 0;
        hi = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            ch += (pin !== last);
            hi += (pin === 1'b1);
            last = pin;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] d;
        rd(`TPG_OFS_MODE, d);
        chk(d, 16'h0001);
        rd(`TPG_OFS_TOGCTL, d);
        chk(d, 16'h0030);
        rd(4'hF, d);
        chk(d, 16'h0000);
        chk(pin, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_ppg();
        logic [15:0] d;
        int ch, hi;
        // low compare below period, both above zero
        wr(`TPG_OFS_CMPLOW, 16'h0001);
        wr(`TPG_OFS_CMPPER, 16'h0004);
        wr(`TPG_OFS_TOGCTL, 16'h0023);
        rd(`TPG_OFS_TOGCTL, d);
        chk(d, 16'h00B3);
        wr(`TPG_OFS_RUN, 16'h0003);
        wait_per();
        watch(20, ch, hi);
        chk(ch, 8);
        chk(hi == 8 || hi == 12, 1);
        wr(`TPG_OFS_TOGCTL, 16'h0031);
        watch(20, ch, hi);
        chk(ch, 4);
        wr(`TPG_OFS_RUN, 16'h0005);
        watch(3, ch, hi);
        chk(pin, 1);
        $display("t_ppg done");
    endtask
    task automatic t_db();
        logic [15:0] d;
        wr(`TPG_OFS_RUN, 16'h0000);
        wr(`TPG_OFS_TOGCTL, 16'h0070);
        wr(`TPG_OFS_CMPLOW, 16'h0002);
        rd(`TPG_OFS_CMPLOW, d);
        chk(d, 16'h0001);
        wr(`TPG_OFS_RUN, 16'h0001);
        wait_per();
        rd(`TPG_OFS_CMPLOW, d);
        chk(d, 16'h0002);
        wr(`TPG_OFS_TOGCTL, 16'h0030);
        wr(`TPG_OFS_CMPLOW, 16'h0003);
        rd(`TPG_OFS_CMPLOW, d);
        chk(d, 16'h0003);
        $display("t_db done");
    endtask
    task automatic t_clear();
        logic [15:0] d;
        repeat (6) begin
            rd(`TPG_OFS_COUNT, d);
            chk(d <= 16'h0004, 1);
        end
        wr(`TPG_OFS_MODE, 16'h0000);
        repeat (10) @(posedge sys_clk);
        rd(`TPG_OFS_COUNT, d);
        chk(d > 16'h0004, 1);
        $display("t_clear done");
    endtask
    task automatic t_cap();
        logic [15:0] c1, c2;
        tpg_pulse_src_i.pulse(0, 6);
        rd(`TPG_OFS_CAPTURE_FIRST, c1);
        chk(c1, 16'h0000);
        wr(`TPG_OFS_MODE, {13'h0, TPG_CAP_DIFF, 1'b0});
        tpg_pulse_src_i.pulse(0, 6);
        tpg_pulse_src_i.pulse(1, 6);
        rd(`TPG_OFS_CAPTURE_FIRST, c1);
        rd(`TPG_OFS_CAPTURE_SECOND, c2);
        chk(c1 != 16'h0000, 1);
        // differences are taken modulo the counter width
        chk(c2 - c1, 16'h000D);
        wr(`TPG_OFS_MODE, {13'h0, TPG_CAP_WIDTH, 1'b0});
        tpg_pulse_src_i.pulse(0, 9);
        // second capture saved before the next trigger edge
        rd(`TPG_OFS_CAPTURE_FIRST, c1);
        rd(`TPG_OFS_CAPTURE_SECOND, c2);
        chk(c2 - c1, 16'h0009);
        wr(`TPG_OFS_MODE, {13'h0, TPG_CAP_GATE, 1'b0});
        tpg_pulse_src_i.pulse(2, 9);
        rd(`TPG_OFS_CAPTURE_FIRST, c1);
        rd(`TPG_OFS_CAPTURE_SECOND, c2);
        chk(c2 - c1, 16'h0009);
        $display("t_cap done");
    endtask
    task automatic t_ext();
        logic [15:0] c0, c1;
        wr(`TPG_OFS_MODE, 16'h0008);
        rd(`TPG_OFS_COUNT, c0);
        repeat (5) tpg_pulse_src_i.pulse(0, 4);
        rd(`TPG_OFS_COUNT, c1);
        chk(c1 - c0, 16'h0005);
        $display("t_ext done");
    endtask
    task automatic t_oneshot();
        wr(`TPG_OFS_MODE, {13'h0, TPG_CAP_DIFF, 1'b0});
        wr(`TPG_OFS_RUN, 16'h0003);
        wr(`TPG_OFS_TOGCTL, 16'h0014);
        tpg_pulse_src_i.pulse(0, 6);
        chk(pin, 1);
        // toggle triggers off once the pulse has started
        wr(`TPG_OFS_TOGCTL, 16'h0030);
        tpg_pulse_src_i.pulse(0, 6);
        chk(pin, 1);
        // invert command flips the output flip-flop
        wr(`TPG_OFS_TOGCTL, 16'h0000);
        @(posedge sys_clk);
        #1;
        chk(pin, 16'h0000);
        $display("t_oneshot done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_ppg();
        t_db();
        t_clear();
        t_cap();
        t_ext();
        t_oneshot();
        give_verdict();
    end
endmodule
